// ==== src/pipe_pkg.sv ====
package pipe_pkg;

  localparam int          ADDR_W     = 32;
  localparam int          REG_W      = 5;
  localparam logic [31:0] RESET_PC   = 32'h0000_0000;
  localparam logic [31:0] PC_STEP    = 32'h0000_0004;
  localparam logic [4:0]  LINK_REG   = 5'h0f;
  localparam logic [4:0]  ZERO_REG   = 5'h00;

  // instruction word fields
  localparam int OPC_HI    = 31;
  localparam int OPC_LO    = 28;
  localparam int RD_HI     = 27;
  localparam int RD_LO     = 23;
  localparam int RS1_HI    = 22;
  localparam int RS1_LO    = 18;
  localparam int RS2_HI    = 17;
  localparam int RS2_LO    = 13;
  localparam int ANNUL_BIT = 12;
  localparam int DISP_HI   = 11;
  localparam int DISP_LO   = 0;
  localparam int DISP_EXT  = 18;

  // instruction classes
  localparam logic [3:0] CLS_ALU  = 4'h0;
  localparam logic [3:0] CLS_LD   = 4'h1;
  localparam logic [3:0] CLS_LDD  = 4'h2;
  localparam logic [3:0] CLS_ST   = 4'h3;
  localparam logic [3:0] CLS_STD  = 4'h4;
  localparam logic [3:0] CLS_LDST = 4'h5;
  localparam logic [3:0] CLS_JUMP_AND_LINK_OP = 4'h6;
  localparam logic [3:0] CLS_RETURN_FROM_TRAP_OP = 4'h7;
  localparam logic [3:0] CLS_CALL = 4'h8;
  localparam logic [3:0] CLS_BR   = 4'h9;

  // operand source selects
  localparam logic [1:0] FWD_RF = 2'h0;
  localparam logic [1:0] FWD_EX = 2'h1;
  localparam logic [1:0] FWD_WR = 2'h2;

  localparam logic [1:0] CNT_0 = 2'h0;
  localparam logic [1:0] CNT_1 = 2'h1;
  localparam logic [1:0] CNT_2 = 2'h2;
  localparam logic [1:0] CNT_3 = 2'h3;

  typedef enum logic [3:0] {
    FS_RUN  = 4'h1,
    FS_DATA = 4'h2,
    FS_NULL = 4'h4,
    FS_TRAP = 4'h8
  } fetch_e;

  typedef struct packed {
    logic        valid;
    logic        internal_opcode;
    logic [31:0] word;
    logic [31:0] pc;
  } dec_s;

  typedef struct packed {
    logic       valid;
    logic       internal_opcode;
    logic       late;
    logic [4:0] rd;
  } stage_s;

  function automatic logic [1:0] iop_count(input logic [3:0] cls);
    case (cls)
      CLS_LD, CLS_JUMP_AND_LINK_OP, CLS_RETURN_FROM_TRAP_OP: iop_count = CNT_1;
      CLS_LDD, CLS_ST:            iop_count = CNT_2;
      CLS_STD, CLS_LDST:          iop_count = CNT_3;
      default:                    iop_count = CNT_0;
    endcase
  endfunction : iop_count

  function automatic logic [1:0] bus_count(input logic [3:0] cls);
    case (cls)
      CLS_LD:             bus_count = CNT_1;
      CLS_LDD, CLS_ST:    bus_count = CNT_2;
      CLS_STD, CLS_LDST:  bus_count = CNT_3;
      default:            bus_count = CNT_0;
    endcase
  endfunction : bus_count

endpackage : pipe_pkg

// ==== src/pipeline_control.sv ====
`timescale 1ns/1ps
module pipeline_control
  import pipe_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [31:0] fetch_word_i,
  input  wire logic        cond_true_i,
  input  wire logic        trap_req_i,
  input  wire logic [31:0] trap_addr_i,
  input  wire logic [1:0]  memory_hold_inputs_i,
  input  wire logic        bus_hold_input_i,
  input  wire logic        stop_i,
  output logic      [31:0] fetch_addr_o,
  output logic             fetch_strobe_o,
  output logic             data_cycle_o,
  output logic             null_cycle_o,
  output logic      [31:0] dec_word_o,
  output logic             dec_iop_o,
  output logic             wb_en_o,
  output logic      [4:0]  wb_reg_o,
  output logic      [1:0]  fwd_rs1_o,
  output logic      [1:0]  fwd_rs2_o
);

  typedef struct packed {
    logic [2:0]       hold_meta;
    logic [2:0]       hold_sync;
    logic             stop_meta;
    logic             stop_sync;
    fetch_e           fst;
    logic [1:0]       bus_cnt;
    logic [31:0]      pc;
    logic             fetch_pend;
    logic [1:0]       pf_valid;
    logic [1:0][31:0] pf_word;
    logic [1:0][31:0] pf_pc;
    logic [31:0]      pend_pc;
    logic             annul_next;
    dec_s             dec;
    logic [1:0]       iop_cnt;
    stage_s           ex;
    stage_s           wr;
    logic [31:0]      addr;
    logic             strobe;
    logic             dcyc;
    logic             ncyc;
    logic             wben;
    logic [4:0]       wbreg;
    logic [1:0]       fwd1;
    logic [1:0]       fwd2;
  } ctl_s;

  ctl_s r_reg;
  ctl_s r_next;

  logic       freeze;
  logic       interlock;
  logic       trap_take;
  logic [3:0] dec_cls;
  logic [4:0] dec_rs1;
  logic [4:0] dec_rs2;

  assign freeze    = (|r_reg.hold_sync) | r_reg.stop_sync;
  assign dec_cls   = r_reg.dec.word[OPC_HI:OPC_LO];
  assign dec_rs1   = r_reg.dec.word[RS1_HI:RS1_LO];
  assign dec_rs2   = r_reg.dec.word[RS2_HI:RS2_LO];
  assign trap_take = trap_req_i & r_reg.ex.valid;

  // late-written destination (load, call link, jump link) read by next one
  assign interlock = r_reg.dec.valid & ~r_reg.dec.internal_opcode & r_reg.ex.valid
                   & r_reg.ex.late & (r_reg.ex.rd != ZERO_REG)
                   & ((dec_rs1 == r_reg.ex.rd)
                   | (dec_rs2 == r_reg.ex.rd));

  function automatic logic [1:0] fwd_sel(input logic [4:0] rs,
                                         input stage_s ex,
                                         input stage_s wr);
    if (rs == ZERO_REG) begin
      fwd_sel = FWD_RF;
    end else if (ex.valid && !ex.internal_opcode && ex.rd == rs) begin
      fwd_sel = FWD_EX;
    end else if (wr.valid && !wr.internal_opcode && wr.rd == rs) begin
      fwd_sel = FWD_WR;
    end else begin
      fwd_sel = FWD_RF;
    end
  endfunction : fwd_sel

  always_comb begin
    logic [1:0]  n_cnt;
    logic        pop;
    logic        redirect;
    logic        full;
    logic [31:0] target;
    n_cnt    = CNT_0;
    pop      = 1'b0;
    redirect = 1'b0;
    full     = 1'b0;
    target   = {{DISP_EXT{r_reg.dec.word[DISP_HI]}},
                r_reg.dec.word[DISP_HI:DISP_LO], 2'h0};
    r_next           = r_reg;
    r_next.hold_meta = {memory_hold_inputs_i, bus_hold_input_i};
    r_next.hold_sync = r_reg.hold_meta;
    r_next.stop_meta = stop_i;
    r_next.stop_sync = r_reg.stop_meta;

    if (!freeze) begin
      r_next.strobe = 1'b0;
      r_next.dcyc   = 1'b0;
      r_next.ncyc   = 1'b0;

      // write stage: retire what execute finished
      r_next.wben  = r_reg.wr.valid & ~r_reg.wr.internal_opcode;
      r_next.wbreg = r_reg.wr.rd;
      r_next.wr    = r_reg.ex;
      if (trap_take) begin
        r_next.wr.valid = 1'b0;
      end

      if (interlock) begin
        // decode holds, a bubble moves into execute
        r_next.ex.valid = 1'b0;
      end else begin
        r_next.ex.valid = r_reg.dec.valid;
        r_next.ex.internal_opcode   = r_reg.dec.internal_opcode;
        r_next.ex.rd    = (dec_cls == CLS_CALL) ? LINK_REG
                        : r_reg.dec.word[RD_HI:RD_LO];
        // internal opcodes of a load keep the late flag, so the
        // instruction after the last one still waits for the data
        r_next.ex.late  = (dec_cls == CLS_LD || dec_cls == CLS_LDD
                        || dec_cls == CLS_LDST || dec_cls == CLS_CALL
                        || dec_cls == CLS_JUMP_AND_LINK_OP);
        if (r_reg.dec.valid && !r_reg.dec.internal_opcode) begin
          n_cnt = iop_count(dec_cls);
          r_next.bus_cnt = bus_count(dec_cls);
          if (dec_cls == CLS_BR) begin
            if (cond_true_i) begin
              redirect  = 1'b1;
              r_next.pc = r_reg.dec.pc + target;
            end
            r_next.annul_next = r_reg.dec.word[ANNUL_BIT];
          end
        end
        if (r_reg.iop_cnt != CNT_0) begin
          r_next.dec.internal_opcode   = 1'b1;
          r_next.iop_cnt   = r_reg.iop_cnt - CNT_1;
        end else if (n_cnt != CNT_0) begin
          r_next.dec.internal_opcode   = 1'b1;
          r_next.iop_cnt   = n_cnt - CNT_1;
        end else if (r_reg.pf_valid[0]) begin
          pop              = 1'b1;
          r_next.dec.internal_opcode   = 1'b0;
          r_next.dec.valid = ~r_next.annul_next;
          r_next.dec.word  = r_reg.pf_word[0];
          r_next.dec.pc    = r_reg.pf_pc[0];
          r_next.annul_next = 1'b0;
        end else begin
          r_next.dec.valid = 1'b0;
        end
        if (r_reg.iop_cnt != CNT_0 || n_cnt != CNT_0) begin
          r_next.dec.valid = 1'b1;
          r_next.dec.word  = r_reg.dec.word;
        end
      end

      // prefetch buffer: shift on pop, push returning fetch
      if (pop) begin
        r_next.pf_valid   = {1'b0, r_reg.pf_valid[1]};
        r_next.pf_word[0] = r_reg.pf_word[1];
        r_next.pf_pc[0]   = r_reg.pf_pc[1];
      end
      if (redirect && pop) begin
        // delay slot leaves now, drop the sequential path behind it
        r_next.pf_valid = 2'h0;
      end
      if (r_reg.fetch_pend) begin
        r_next.fetch_pend = 1'b0;
        if (!(redirect && pop)) begin
          if (r_next.pf_valid[0]) begin
            r_next.pf_valid[1] = 1'b1;
            r_next.pf_word[1]  = fetch_word_i;
            r_next.pf_pc[1]    = r_reg.pend_pc;
          end else begin
            r_next.pf_valid[0] = 1'b1;
            r_next.pf_word[0]  = fetch_word_i;
            r_next.pf_pc[0]    = r_reg.pend_pc;
          end
        end
      end
      full = (&r_next.pf_valid)
           | (|r_next.pf_valid & r_next.fetch_pend);

      // fetch unit mode for this cycle
      if (trap_take) begin
        r_next.fst = FS_TRAP;
      end else if (r_next.bus_cnt != CNT_0) begin
        r_next.fst = FS_DATA;
      end else if (interlock) begin
        r_next.fst = FS_NULL;
      end else begin
        r_next.fst = FS_RUN;
      end

      case (r_next.fst)
        FS_TRAP: begin
          // flush everything younger than the trapping instruction
          r_next.pc         = trap_addr_i;
          r_next.dec.valid  = 1'b0;
          r_next.ex.valid   = 1'b0;
          r_next.pf_valid   = 2'h0;
          r_next.fetch_pend = 1'b0;
          r_next.iop_cnt    = CNT_0;
          r_next.bus_cnt    = CNT_0;
          r_next.annul_next = 1'b0;
        end
        FS_DATA: begin
          r_next.dcyc    = 1'b1;
          r_next.bus_cnt = r_next.bus_cnt - CNT_1;
        end
        FS_NULL: begin
          r_next.ncyc = 1'b1;
        end
        FS_RUN: begin
          if (!full && !redirect) begin
            r_next.addr       = r_reg.pc;
            r_next.strobe     = 1'b1;
            r_next.pend_pc    = r_reg.pc;
            r_next.fetch_pend = 1'b1;
            r_next.pc         = r_reg.pc + PC_STEP;
          end else if (redirect && !full) begin
            r_next.addr       = r_next.pc;
            r_next.strobe     = 1'b1;
            r_next.pend_pc    = r_next.pc;
            r_next.fetch_pend = 1'b1;
            r_next.pc         = r_next.pc + PC_STEP;
          end
        end
        default: begin
          r_next.fst = FS_RUN;
        end
      endcase

      // operand sources for the instruction now entering decode
      r_next.fwd1 = fwd_sel(r_next.dec.word[RS1_HI:RS1_LO],
                            r_next.ex, r_next.wr);
      r_next.fwd2 = fwd_sel(r_next.dec.word[RS2_HI:RS2_LO],
                            r_next.ex, r_next.wr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r_reg       <= '0;
      r_reg.fst   <= FS_RUN;
      r_reg.pc    <= RESET_PC;
    end else begin
      r_reg <= r_next;
    end
  end

  assign fetch_addr_o   = r_reg.addr;
  assign fetch_strobe_o = r_reg.strobe;
  assign data_cycle_o   = r_reg.dcyc;
  assign null_cycle_o   = r_reg.ncyc;
  assign dec_word_o     = r_reg.dec.word;
  assign dec_iop_o      = r_reg.dec.internal_opcode & r_reg.dec.valid;
  assign wb_en_o        = r_reg.wben;
  assign wb_reg_o       = r_reg.wbreg;
  assign fwd_rs1_o      = r_reg.fwd1;
  assign fwd_rs2_o      = r_reg.fwd2;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  hold_freeze_a: assert property (
    (|r_reg.hold_sync) |=> $stable(r_reg.pc) && $stable(r_reg.dec))
    else $error("pipeline moved during hold");

  stop_freeze_a: assert property (
    r_reg.stop_sync |=> $stable(fetch_addr_o) && $stable(r_reg.ex))
    else $error("pipeline moved during stop");

  reset_pc_a: assert property (
    $fell(reset_i) |-> r_reg.pc == RESET_PC)
    else $error("fetch does not start at zero");

  interlock_null_a: assert property (
    (interlock && !freeze) |=> null_cycle_o && !fetch_strobe_o)
    else $error("no null cycle during interlock");

  interlock_bubble_a: assert property (
    (interlock && !freeze) |=> !r_reg.ex.valid && r_reg.dec.valid)
    else $error("dependent instruction not stalled");

  trap_flush_a: assert property (
    (trap_take && !freeze) |=> !r_reg.dec.valid && r_reg.pf_valid == 2'h0
      && r_reg.pc == $past(trap_addr_i))
    else $error("trap did not flush pipeline");

  trap_nowrite_a: assert property (
    (trap_take && !freeze && !(|r_reg.hold_meta) && !r_reg.stop_meta)
      |=> ##1 !wb_en_o)
    else $error("trapped instruction written back");

  buffer_bound_a: assert property (
    !((&r_reg.pf_valid) && r_reg.fetch_pend))
    else $error("prefetch buffer overflow");

  data_cycle_a: assert property (
    (r_reg.bus_cnt != CNT_0 && !freeze && !trap_take)
      |=> data_cycle_o && !fetch_strobe_o)
    else $error("data cycle did not block fetch");

  load_data_a: assert property (
    (r_reg.dec.valid && !r_reg.dec.internal_opcode && dec_cls == CLS_LD && !interlock
      && !freeze && !trap_take) |=> data_cycle_o && !fetch_strobe_o)
    else $error("load did not start a data cycle");

endmodule : pipeline_control

// ==== dv/fetch_memory.sv ====
`timescale 1ns/1ps
module fetch_memory (
  input  wire logic        clk_i,
  input  wire logic [31:0] fetch_addr_i,
  input  wire logic        fetch_strobe_i,
  input  wire logic        hold_i,
  output logic      [31:0] fetch_word_o
);
  logic [31:0] mem [64];
  logic [2:0]  hold_reg;

  initial begin
    fetch_word_o = 32'h0000_0000;
    hold_reg     = 3'h0;
    foreach (mem[i]) mem[i] = 32'h0000_0000;
  end

  always @(posedge clk_i) begin
    hold_reg <= {hold_reg[1:0], hold_i};
  end

  // word is returned inside the strobe cycle and taken at its closing edge;
  // it is kept only while a hold may freeze the pipeline, else goes stale
  always @(negedge clk_i) begin
    if (fetch_strobe_i) begin
      fetch_word_o <= mem[fetch_addr_i[7:2]];
    end else if (!(hold_i || (|hold_reg))) begin
      fetch_word_o <= ~fetch_word_o;
    end
  end
endmodule : fetch_memory

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  import pipe_pkg::*;
  typedef struct {
    logic [31:0] w0;
    logic [31:0] w1;
    int          dat;
    int          internal_opcode;
    int          nul;
    int          fwd;
  } row_s;

  logic        clk_i, reset_i, cond_true_i, trap_req_i;
  logic        bus_hold_input_i, stop_i, fetch_strobe_o, data_cycle_o;
  logic        null_cycle_o, dec_iop_o, wb_en_o;
  logic [1:0]  memory_hold_inputs_i, fwd_rs1_o, fwd_rs2_o;
  logic [4:0]  wb_reg_o;
  logic [31:0] fetch_word_i, trap_addr_i, fetch_addr_o, dec_word_o, a_seen;
  logic [31:0] q[$];
  row_s        rows[9];
  int          n_mismatch, check_count, n_dat, n_iop, n_nul, n_fwd;
  int          n_cyc, t_first, hit;

  pipeline_control dut (.clk_i(clk_i), .reset_i(reset_i),
    .fetch_word_i(fetch_word_i), .cond_true_i(cond_true_i),
    .trap_req_i(trap_req_i), .trap_addr_i(trap_addr_i),
    .memory_hold_inputs_i(memory_hold_inputs_i),
    .bus_hold_input_i(bus_hold_input_i), .stop_i(stop_i),
    .fetch_addr_o(fetch_addr_o), .fetch_strobe_o(fetch_strobe_o),
    .data_cycle_o(data_cycle_o), .null_cycle_o(null_cycle_o),
    .dec_word_o(dec_word_o), .dec_iop_o(dec_iop_o), .wb_en_o(wb_en_o),
    .wb_reg_o(wb_reg_o), .fwd_rs1_o(fwd_rs1_o), .fwd_rs2_o(fwd_rs2_o));

  fetch_memory mem_model (.clk_i(clk_i), .fetch_addr_i(fetch_addr_o),
    .fetch_strobe_i(fetch_strobe_o),
    .hold_i(stop_i | bus_hold_input_i | (|memory_hold_inputs_i)),
    .fetch_word_o(fetch_word_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (reset_i === 1'b0) begin
      n_cyc++;
      if (data_cycle_o === 1'b1) n_dat++;
      if (dec_iop_o === 1'b1) n_iop++;
      if (null_cycle_o === 1'b1) n_nul++;
      if (fwd_rs1_o === FWD_EX) n_fwd++;
      if (fetch_strobe_o === 1'b1) begin
        q.push_back(fetch_addr_o);
        if (t_first < 0) t_first = n_cyc;
      end
    end
  end

  function automatic logic [31:0] mk(input logic [3:0] c, input logic [4:0] d,
                                     input logic [4:0] s1, input logic a,
                                     input logic [11:0] disp);
    mk = {c, d, s1, 5'h00, a, disp};
  endfunction : mk

  function automatic int has(input logic [31:0] v);
    has = 0;
    foreach (q[i]) if (q[i] === v) has = 1;
  endfunction : has

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // reset, load two words at address zero, then run 24 cycles
  task automatic run(input logic [31:0] w0, input logic [31:0] w1);
    mem_model.mem[0] = w0;
    mem_model.mem[1] = w1;
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("reset outs", 32'h0, {fetch_strobe_o, data_cycle_o, null_cycle_o,
        wb_en_o, dec_iop_o});
    reset_i = 1'b0;
    n_cyc = 0; n_dat = 0; n_iop = 0; n_nul = 0; n_fwd = 0;
    t_first = -1;
    q.delete();
    repeat (24) @(negedge clk_i);
  endtask : run

  initial begin
    reset_i = 1'b1; cond_true_i = 1'b0; trap_req_i = 1'b0;
    trap_addr_i = 32'h0000_0100; memory_hold_inputs_i = 2'h0;
    bus_hold_input_i = 1'b0; stop_i = 1'b0;
    n_mismatch = 0; check_count = 0; n_cyc = 0; t_first = -1;
    rows = '{
      '{mk(CLS_ALU, 5'h03, 5'h00, 1'b0, 12'h0),
        mk(CLS_ALU, 5'h04, 5'h03, 1'b0, 12'h0), 0, 0, 0, 1},
      '{mk(CLS_LD, 5'h05, 5'h00, 1'b0, 12'h0),
        mk(CLS_ALU, 5'h04, 5'h05, 1'b0, 12'h0), 1, -1, 1, -1},
      '{mk(CLS_LD, 5'h05, 5'h00, 1'b0, 12'h0),
        mk(CLS_ALU, 5'h04, 5'h06, 1'b0, 12'h0), 1, 1, 0, -1},
      '{mk(CLS_LDD, 5'h06, 5'h00, 1'b0, 12'h0), 32'h0, 2, 2, 0, -1},
      '{mk(CLS_ST, 5'h05, 5'h00, 1'b0, 12'h0), 32'h0, 2, 2, 0, -1},
      '{mk(CLS_STD, 5'h06, 5'h00, 1'b0, 12'h0), 32'h0, 3, 3, 0, -1},
      '{mk(CLS_LDST, 5'h05, 5'h00, 1'b0, 12'h0), 32'h0, 3, 3, 0, -1},
      '{mk(CLS_JUMP_AND_LINK_OP, 5'h09, 5'h00, 1'b0, 12'h0), 32'h0, 0, 1, 0, -1},
      '{mk(CLS_RETURN_FROM_TRAP_OP, 5'h00, 5'h00, 1'b0, 12'h0), 32'h0, 0, 1, 0, -1}};
    foreach (rows[i]) begin
      run(rows[i].w0, rows[i].w1);
      chk("data cycles", rows[i].dat, n_dat);
      if (rows[i].internal_opcode >= 0) chk("iops", rows[i].internal_opcode, n_iop);
      chk("null cycles", rows[i].nul, n_nul);
      // an opcode cycle without a data cycle finds the buffer full
      hit = rows[i].internal_opcode > rows[i].dat ? rows[i].internal_opcode : rows[i].dat;
      chk("fetches", 23 - hit - rows[i].nul, q.size());
      if (rows[i].fwd >= 0) chk("forward", rows[i].fwd, n_fwd);
    end
    // start address and back-to-back fetching
    run(32'h0, 32'h0);
    chk("first fetch time", 32'd2, t_first);
    chk("first addr", RESET_PC, q[0]);
    chk("second addr", RESET_PC + PC_STEP, q[1]);
    // freeze by each hold source and by stop, then resume
    for (int s = 0; s < 4; s++) begin
      {stop_i, bus_hold_input_i, memory_hold_inputs_i} = 4'h1 << s;
      repeat (3) @(negedge clk_i);
      a_seen = fetch_addr_o;
      hit = fetch_strobe_o;
      repeat (4) @(negedge clk_i);
      chk("frozen addr", a_seen, fetch_addr_o);
      chk("frozen strobe", hit, fetch_strobe_o);
      {stop_i, bus_hold_input_i, memory_hold_inputs_i} = 4'h0;
      repeat (6) @(negedge clk_i);
      chk("resumed", 1, fetch_addr_o !== a_seen);
    end
    // trap: handler fetched two cycles after the trap edge
    trap_req_i = 1'b1;
    @(negedge clk_i);
    trap_req_i = 1'b0;
    hit = 0;
    for (int i = 2; i < 9 && hit == 0; i++) begin
      @(negedge clk_i);
      if (fetch_strobe_o === 1'b1 && fetch_addr_o === 32'h100) hit = i;
    end
    chk("handler fetch", 32'd2, hit);
    // taken branch with and without annulled delay-slot load
    cond_true_i = 1'b1;
    for (int a = 0; a < 2; a++) begin
      run(mk(CLS_BR, 5'h00, 5'h00, a[0], 12'h004),
          mk(CLS_LD, 5'h05, 5'h00, 1'b0, 12'h0));
      chk("slot load", a == 0 ? 1 : 0, n_dat);
      chk("target fetched", 1, has(32'h10));
      chk("fallthrough skipped", 0, has(32'h0c));
    end
    close_out();
  end
endmodule : tb
